// *** lmq_defs.svh ***
// register offsets, field layouts and constants of the legacy queue register bank
`ifndef LMQ_DEFS_SVH
`define LMQ_DEFS_SVH
`define LMQ_OFF_MAGIC 12'h000
`define LMQ_OFF_REVISION 12'h004
`define LMQ_OFF_DEVCODE 12'h008
`define LMQ_OFF_MAKER 12'h00c
`define LMQ_OFF_OFFERED 12'h010
`define LMQ_OFF_OFFERED_SEL 12'h014
`define LMQ_OFF_ACCEPTED 12'h020
`define LMQ_OFF_ACCEPTED_SEL 12'h024
`define LMQ_OFF_PAGE_BYTES 12'h028
`define LMQ_OFF_RING_SEL 12'h030
`define LMQ_OFF_CAP_LIMIT 12'h034
`define LMQ_OFF_ELEM_COUNT 12'h038
`define LMQ_OFF_ALIGN 12'h03c
`define LMQ_OFF_PAGE_FRAME 12'h040
`define LMQ_OFF_DOORBELL 12'h050
`define LMQ_OFF_IRQ_FLAGS 12'h060
`define LMQ_OFF_IRQ_CLEAR 12'h064
`define LMQ_OFF_STATUS 12'h070
`define LMQ_REVISION_LEGACY 32'h0000_0001
`define LMQ_RING_COUNT 4
`define LMQ_RING_IDX_W 2
`define LMQ_FEAT_WORDS 2
`define LMQ_IRQ_BITS 2
`define LMQ_PAGE_SHIFT_W 6
`define LMQ_PAGE_RESET 32'h0000_1000
`define LMQ_SHIFT_RESET 6'h0c
`endif

// *** lmq_pkg.sv ***
// types of the legacy queue register bank
package lmq_pkg;
    typedef struct packed {
        logic [31:0] elem_count;
        logic [31:0] align;
        logic [31:0] page_frame;
    } lmq_ring_t;
    typedef struct packed {
        logic valid;
        logic write;
        logic [11:0] addr;
        logic [31:0] wdata;
    } lmq_req_t;
    typedef enum logic [1:0] {
        LMQ_IDLE = 2'b01,
        LMQ_RESP = 2'b10
    } lmq_phase_t;
    typedef struct packed {
        lmq_phase_t phase;
        logic [31:0] rdata;
        logic [31:0] offered_sel;
        logic [31:0] accepted_sel;
        logic [63:0] accepted;
        logic [31:0] page_bytes;
        logic [5:0] page_shift;
        logic [31:0] ring_sel;
        logic [1:0] irq_flags;
        logic [7:0] status;
        logic notify_valid;
        logic [31:0] notify_idx;
        lmq_ring_t [3:0] rings;
    } lmq_state_t;
endpackage

// *** lmq_regs.sv ***
// register bank of the page-based legacy paravirtual queue device
`include "lmq_defs.svh"
module lmq_regs
    import lmq_pkg::*;
#(
    parameter logic [31:0] MAGIC_SIGNATURE = 32'h1234_5678, // arbitrary
    parameter logic [31:0] DEVICE_CODE = 32'h0000_00a5, // arbitrary
    parameter logic [31:0] MAKER_CODE = 32'h0000_5a5a, // arbitrary
    parameter logic [63:0] OFFERED_FEATURES = 64'h0000_0001_0000_0003,
    parameter logic [31:0] RING_CAPACITY = 32'h0000_0100,
    parameter logic [3:0] RING_PRESENT = 4'b0011
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic req_valid_i,
    input wire logic req_write_i,
    input wire logic [11:0] req_addr_i,
    input wire logic [31:0] req_wdata_i,
    output logic resp_valid_o,
    output logic [31:0] resp_rdata_o,
    input wire logic [1:0] irq_event_i,
    output logic irq_o,
    output logic notify_valid_o,
    output logic [31:0] notify_idx_o,
    output logic [31:0] page_bytes_o,
    output logic [63:0] accepted_features_o,
    output logic [3:0] ring_active_o,
    output logic [255:0] ring_base_o
);
    lmq_state_t st_reg;
    lmq_state_t st_next;
    lmq_req_t req;
    logic [1:0] sel_idx;
    logic sel_in_range;
    logic dev_reset;
    logic [31:0] rd_val;

    // pack the incoming request
    assign req = '{valid: req_valid_i, write: req_write_i,
                   addr: req_addr_i, wdata: req_wdata_i};
    assign sel_idx = st_reg.ring_sel[1:0];
    assign sel_in_range = (st_reg.ring_sel < `LMQ_RING_COUNT);
    // device reset comes from a zero write to the status word
    assign dev_reset = req.valid && req.write &&
                       (req.addr == `LMQ_OFF_STATUS) && (req.wdata == '0);

    // read multiplexer, address decode by if chain
    always_comb begin
        rd_val = '0;
        if (req.addr == `LMQ_OFF_MAGIC) begin
            rd_val = MAGIC_SIGNATURE;
        end else if (req.addr == `LMQ_OFF_REVISION) begin
            rd_val = `LMQ_REVISION_LEGACY;
        end else if (req.addr == `LMQ_OFF_DEVCODE) begin
            rd_val = DEVICE_CODE;
        end else if (req.addr == `LMQ_OFF_MAKER) begin
            rd_val = MAKER_CODE;
        end else if (req.addr == `LMQ_OFF_OFFERED) begin
            if (st_reg.offered_sel < `LMQ_FEAT_WORDS) begin
                rd_val = OFFERED_FEATURES[st_reg.offered_sel[0]*32 +: 32];
            end
        end else if (req.addr == `LMQ_OFF_CAP_LIMIT) begin
            if (sel_in_range && RING_PRESENT[sel_idx]) begin
                rd_val = RING_CAPACITY;
            end
        end else if (req.addr == `LMQ_OFF_PAGE_FRAME) begin
            if (sel_in_range) begin
                rd_val = st_reg.rings[sel_idx].page_frame;
            end
        end else if (req.addr == `LMQ_OFF_IRQ_FLAGS) begin
            rd_val = {30'h0, st_reg.irq_flags};
        end else if (req.addr == `LMQ_OFF_STATUS) begin
            rd_val = {24'h0, st_reg.status};
        end
    end

    // next-state logic of the whole bank
    always_comb begin
        st_next = st_reg;
        st_next.notify_valid = 1'b0;
        st_next.phase = LMQ_IDLE;
        if (req.valid) begin
            st_next.phase = LMQ_RESP;
            if (!req.write) begin
                st_next.rdata = rd_val;
            end
        end
        if (req.valid && req.write) begin
            if (req.addr == `LMQ_OFF_OFFERED_SEL) begin
                st_next.offered_sel = req.wdata;
            end else if (req.addr == `LMQ_OFF_ACCEPTED_SEL) begin
                st_next.accepted_sel = req.wdata;
            end else if (req.addr == `LMQ_OFF_ACCEPTED) begin
                if (st_reg.accepted_sel < `LMQ_FEAT_WORDS) begin
                    st_next.accepted[st_reg.accepted_sel[0]*32 +: 32] =
                        req.wdata;
                end
            end else if (req.addr == `LMQ_OFF_PAGE_BYTES) begin
                st_next.page_bytes = req.wdata;
                st_next.page_shift = '0;
                for (int b = 0; b < 32; b++) begin
                    if (req.wdata[b]) begin
                        st_next.page_shift = 6'(b); // highest set bit
                    end
                end
            end else if (req.addr == `LMQ_OFF_RING_SEL) begin
                st_next.ring_sel = req.wdata;
            end else if (req.addr == `LMQ_OFF_ELEM_COUNT) begin
                if (sel_in_range) begin
                    st_next.rings[sel_idx].elem_count = req.wdata;
                end
            end else if (req.addr == `LMQ_OFF_ALIGN) begin
                if (sel_in_range) begin
                    st_next.rings[sel_idx].align = req.wdata;
                end
            end else if (req.addr == `LMQ_OFF_PAGE_FRAME) begin
                if (sel_in_range && RING_PRESENT[sel_idx]) begin
                    st_next.rings[sel_idx].page_frame = req.wdata;
                end
            end else if (req.addr == `LMQ_OFF_DOORBELL) begin
                st_next.notify_valid = 1'b1;
                st_next.notify_idx = req.wdata;
            end else if (req.addr == `LMQ_OFF_STATUS) begin
                st_next.status = st_reg.status | req.wdata[7:0];
            end
        end
        // acknowledge clears, a new event in the same cycle wins
        if (req.valid && req.write && (req.addr == `LMQ_OFF_IRQ_CLEAR)) begin
            st_next.irq_flags = st_reg.irq_flags & ~req.wdata[1:0];
        end
        st_next.irq_flags = st_next.irq_flags | irq_event_i;
        // status zero write resets queue state, flags keep only same-cycle events
        if (dev_reset) begin
            st_next.status = '0;
            st_next.irq_flags = irq_event_i;
            st_next.page_bytes = `LMQ_PAGE_RESET;
            st_next.page_shift = `LMQ_SHIFT_RESET;
            for (int r = 0; r < `LMQ_RING_COUNT; r++) begin
                st_next.rings[r] = '0;
            end
        end
    end

    // state register
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_reg <= '{phase: LMQ_IDLE, page_bytes: `LMQ_PAGE_RESET,
                        page_shift: `LMQ_SHIFT_RESET, default: '0};
        end else begin
            st_reg <= st_next;
        end
    end

    // per-ring base address and active flag
    generate
        for (genvar g = 0; g < `LMQ_RING_COUNT; g++) begin : g_ring
            logic [63:0] base_full;
            assign base_full = {32'h0, st_reg.rings[g].page_frame}
                               << st_reg.page_shift;
            assign ring_base_o[g*64 +: 64] = base_full;
            assign ring_active_o[g] =
                (st_reg.rings[g].page_frame != '0);
        end
    endgenerate

    // outputs
    assign resp_valid_o = (st_reg.phase == LMQ_RESP);
    assign resp_rdata_o = st_reg.rdata;
    assign irq_o = |st_reg.irq_flags;
    assign notify_valid_o = st_reg.notify_valid;
    assign notify_idx_o = st_reg.notify_idx;
    assign page_bytes_o = st_reg.page_bytes;
    assign accepted_features_o = st_reg.accepted;

    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    rev_read_a: assert property (req_valid_i && !req_write_i &&
        req_addr_i == `LMQ_OFF_REVISION |=> resp_valid_o &&
        resp_rdata_o == 32'h0000_0001) else $error("bad revision");
    irq_level_a: assert property (irq_o == (st_reg.irq_flags != 2'b00))
        else $error("irq mismatch");
    flag_hold_a: assert property (irq_event_i[0] |=> st_reg.irq_flags[0])
        else $error("event lost");
    flag_stick_a: assert property (st_reg.irq_flags[0] && !irq_event_i[0]
        && !(req_valid_i && req_write_i) |=> st_reg.irq_flags[0])
        else $error("flag dropped");
    reset_clear_a: assert property (dev_reset |=> ring_active_o == 4'h0)
        else $error("reset kept rings");
    frame_store_a: assert property (req_valid_i && req_write_i &&
        req_addr_i == `LMQ_OFF_PAGE_FRAME && st_reg.ring_sel == 32'h0 &&
        RING_PRESENT[0] |=> st_reg.rings[0].page_frame == $past(req_wdata_i))
        else $error("frame not stored");
    active_zero_a: assert property (st_reg.rings[1].page_frame == 32'h0
        |-> !ring_active_o[1]) else $error("zero frame active");
    feat_high_a: assert property (req_valid_i && !req_write_i &&
        req_addr_i == `LMQ_OFF_OFFERED && st_reg.offered_sel > 32'h1
        |=> resp_rdata_o == 32'h0) else $error("feature word");
    sel_count_a: assert property (req_valid_i && req_write_i &&
        req_addr_i == `LMQ_OFF_ELEM_COUNT && st_reg.ring_sel == 32'h1
        |=> st_reg.rings[1].elem_count == $past(req_wdata_i))
        else $error("count not stored");
    resp_one_a: assert property (req_valid_i |=> resp_valid_o)
        else $error("no response");
    resp_idle_a: assert property (!req_valid_i |=> !resp_valid_o)
        else $error("stray response");
    cov_irq_c: cover property (irq_event_i[0] ##[1:4] !irq_o);
    cov_reset_c: cover property (ring_active_o[0] ##1 dev_reset);
    cov_bell_c: cover property (notify_valid_o);
    cov_ack_c: cover property (irq_o ##1 !irq_o);
    cov_feat_c: cover property (accepted_features_o[31:0] != 32'h0);

    // identity words read back as the fixed parameters
    magic_read_a: assert property (req_valid_i && !req_write_i &&
        req_addr_i == `LMQ_OFF_MAGIC |=> resp_rdata_o == MAGIC_SIGNATURE)
        else $error("bad signature");
    devcode_read_a: assert property (req_valid_i && !req_write_i &&
        req_addr_i == `LMQ_OFF_DEVCODE |=> resp_rdata_o == DEVICE_CODE)
        else $error("bad device code");
    maker_read_a: assert property (req_valid_i && !req_write_i &&
        req_addr_i == `LMQ_OFF_MAKER |=> resp_rdata_o == MAKER_CODE)
        else $error("bad maker code");
    // unmapped reads answer zero, read data holds between reads
    unmapped_read_a: assert property (req_valid_i && !req_write_i &&
        req_addr_i == 12'h0f0 |=> resp_rdata_o == 32'h0)
        else $error("unmapped read");
    rdata_hold_a: assert property (!(req_valid_i && !req_write_i)
        |=> $stable(resp_rdata_o)) else $error("read data moved");

    // capacity reads follow ring presence
    cap_present_a: assert property (req_valid_i && !req_write_i &&
        req_addr_i == `LMQ_OFF_CAP_LIMIT && st_reg.ring_sel == 32'h0 &&
        RING_PRESENT[0] |=> resp_rdata_o == RING_CAPACITY)
        else $error("capacity missing");
    cap_absent_a: assert property (req_valid_i && !req_write_i &&
        req_addr_i == `LMQ_OFF_CAP_LIMIT && st_reg.ring_sel == 32'h2 &&
        !RING_PRESENT[2] |=> resp_rdata_o == 32'h0)
        else $error("absent ring capacity");
    // page frame read returns the stored frame of the selected ring
    frame_read_a: assert property (req_valid_i && !req_write_i &&
        req_addr_i == `LMQ_OFF_PAGE_FRAME && st_reg.ring_sel == 32'h1
        |=> resp_rdata_o == $past(st_reg.rings[1].page_frame))
        else $error("frame read");

    // stored ring settings and refused frame writes
    align_store_a: assert property (req_valid_i && req_write_i &&
        req_addr_i == `LMQ_OFF_ALIGN && st_reg.ring_sel == 32'h1
        |=> st_reg.rings[1].align == $past(req_wdata_i))
        else $error("align not stored");
    absent_frame_a: assert property (req_valid_i && req_write_i &&
        req_addr_i == `LMQ_OFF_PAGE_FRAME && st_reg.ring_sel == 32'h2 &&
        !RING_PRESENT[2] |=> !ring_active_o[2])
        else $error("absent ring active");
    range_drop_a: assert property (req_valid_i && req_write_i &&
        req_addr_i == `LMQ_OFF_ELEM_COUNT && st_reg.ring_sel == 32'h4
        |=> $stable(st_reg.rings))
        else $error("out of range write");
    stop_ring_a: assert property (req_valid_i && req_write_i &&
        req_addr_i == `LMQ_OFF_PAGE_FRAME && st_reg.ring_sel == 32'h1 &&
        req_wdata_i == 32'h0 |=> !ring_active_o[1])
        else $error("stopped ring active");
    frame_zero_a: assert property (st_reg.rings[0].page_frame == 32'h0
        |-> !ring_active_o[0]) else $error("zero frame active");

    // page size and selector registers take the written word
    page_store_a: assert property (req_valid_i && req_write_i &&
        req_addr_i == `LMQ_OFF_PAGE_BYTES
        |=> page_bytes_o == $past(req_wdata_i))
        else $error("page size lost");
    base_shift_a: assert property (page_bytes_o == 32'h0000_2000
        |-> ring_base_o[127:64] == {19'h0, st_reg.rings[1].page_frame, 13'h0})
        else $error("base address");
    ring_sel_a: assert property (req_valid_i && req_write_i &&
        req_addr_i == `LMQ_OFF_RING_SEL
        |=> st_reg.ring_sel == $past(req_wdata_i))
        else $error("ring select lost");
    offered_sel_a: assert property (req_valid_i && req_write_i &&
        req_addr_i == `LMQ_OFF_OFFERED_SEL
        |=> st_reg.offered_sel == $past(req_wdata_i))
        else $error("offered select lost");
    accepted_sel_a: assert property (req_valid_i && req_write_i &&
        req_addr_i == `LMQ_OFF_ACCEPTED_SEL
        |=> st_reg.accepted_sel == $past(req_wdata_i))
        else $error("accepted select lost");
    feat_low_a: assert property (req_valid_i && !req_write_i &&
        req_addr_i == `LMQ_OFF_OFFERED && st_reg.offered_sel == 32'h0
        |=> resp_rdata_o == OFFERED_FEATURES[31:0])
        else $error("offered word 0");

    // accepted feature words, undefined words dropped
    accept_word_a: assert property (req_valid_i && req_write_i &&
        req_addr_i == `LMQ_OFF_ACCEPTED && st_reg.accepted_sel == 32'h0
        |=> accepted_features_o[31:0] == $past(req_wdata_i))
        else $error("accepted word lost");
    accept_drop_a: assert property (req_valid_i && req_write_i &&
        req_addr_i == `LMQ_OFF_ACCEPTED && st_reg.accepted_sel > 32'h1
        |=> $stable(accepted_features_o)) else $error("word not dropped");

    // interrupt flags: acknowledge, undefined bits, device reset
    ack_clear_a: assert property (req_valid_i && req_write_i &&
        req_addr_i == `LMQ_OFF_IRQ_CLEAR && req_wdata_i[0] &&
        !irq_event_i[0] |=> !st_reg.irq_flags[0])
        else $error("ack ignored");
    undef_flags_a: assert property (req_valid_i && !req_write_i &&
        req_addr_i == `LMQ_OFF_IRQ_FLAGS |=> resp_rdata_o[31:2] == 30'h0)
        else $error("undefined flag bits");
    reset_flags_a: assert property (dev_reset && irq_event_i == 2'b00
        |=> !irq_o) else $error("flags survive reset");
    reset_page_a: assert property (dev_reset
        |=> page_bytes_o == `LMQ_PAGE_RESET) else $error("page not reset");

    // doorbell pulse only after a doorbell write
    bell_pulse_a: assert property (req_valid_i && req_write_i &&
        req_addr_i == `LMQ_OFF_DOORBELL |=> notify_valid_o &&
        notify_idx_o == $past(req_wdata_i)) else $error("doorbell lost");
    bell_quiet_a: assert property (!(req_valid_i && req_write_i &&
        req_addr_i == `LMQ_OFF_DOORBELL) |=> !notify_valid_o)
        else $error("stray doorbell");
endmodule

// *** test_legacy_mmio_queue_regs.sv ***
// self-checking bench of the legacy queue register bank
`include "lmq_defs.svh"
module test_legacy_mmio_queue_regs;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic req_valid_i = 1'b0;
    logic req_write_i = 1'b0;
    logic [11:0] req_addr_i = 12'h000;
    logic [31:0] req_wdata_i = 32'h0000_0000;
    logic [1:0] irq_event_i = 2'b00;
    logic resp_valid_o, irq_o, notify_valid_o, rang;
    logic [31:0] resp_rdata_o, notify_idx_o, page_bytes_o, rd;
    logic [63:0] accepted_features_o;
    logic [3:0] ring_active_o;
    logic [255:0] ring_base_o;
    int errors = 0;
    int comparisons = 0;
    lmq_regs u_lmq_regs (.clk_i(clk_i), .nrst_i(nrst_i),
        .req_valid_i(req_valid_i), .req_write_i(req_write_i),
        .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
        .resp_valid_o(resp_valid_o), .resp_rdata_o(resp_rdata_o),
        .irq_event_i(irq_event_i), .irq_o(irq_o),
        .notify_valid_o(notify_valid_o), .notify_idx_o(notify_idx_o),
        .page_bytes_o(page_bytes_o),
        .accepted_features_o(accepted_features_o),
        .ring_active_o(ring_active_o), .ring_base_o(ring_base_o));
    // free-running 100 MHz clock
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    // one compare for every kind of result, widened to 64 bits
    task automatic chk(input string what, input logic [63:0] exp,
                       input logic [63:0] got);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one register access: request held for one edge, answer read just after that same edge
    task automatic acc(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge clk_i);
        #1;
        req_valid_i = 1'b1;
        req_write_i = wr;
        req_addr_i = a;
        req_wdata_i = d;
        @(posedge clk_i);
        #1;
        req_valid_i = 1'b0;
        chk("resp_valid", 64'h1, 64'(resp_valid_o));
        rd = resp_rdata_o;
        rang = notify_valid_o;
    endtask
    // one-cycle event pulse on the interrupt cause inputs
    task automatic pulse(input logic [1:0] ev);
        @(posedge clk_i);
        #1;
        irq_event_i = ev;
        @(posedge clk_i);
        #1;
        irq_event_i = 2'b00;
    endtask
    task automatic final_report;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // hang guard, far beyond the roughly 90 cycles the tests need
    initial begin
        #200000;
        errors++;
        final_report();
    end
    // main sequence
    initial begin
        repeat (12) @(posedge clk_i);
        #1;
        nrst_i = 1'b1;
        chk("page_rst", 64'h1000, 64'(page_bytes_o));
        chk("active_rst", 64'h0, 64'(ring_active_o));
        acc(1'b0, `LMQ_OFF_REVISION, 32'h0000_0000);
        chk("revision", 64'h1, 64'(rd));
        acc(1'b0, 12'h0f0, 32'h0000_0000);
        chk("unmapped", 64'h0, 64'(rd));
        // capacity per ring: rings 0 and 1 present, others absent
        for (int g = 0; g < 4; g++) begin
            acc(1'b1, `LMQ_OFF_RING_SEL, 32'(g));
            acc(1'b0, `LMQ_OFF_CAP_LIMIT, 32'h0000_0000);
            chk("cap", (g < 2) ? 64'h100 : 64'h0, 64'(rd));
        end
        acc(1'b1, `LMQ_OFF_PAGE_BYTES, 32'h0000_2000);
        chk("page", 64'h2000, 64'(page_bytes_o));
        acc(1'b1, `LMQ_OFF_RING_SEL, 32'h0000_0001);
        acc(1'b1, `LMQ_OFF_ELEM_COUNT, 32'h0000_0040);
        acc(1'b1, `LMQ_OFF_ALIGN, 32'h0000_1000);
        acc(1'b1, `LMQ_OFF_PAGE_FRAME, 32'h0000_0005);
        acc(1'b0, `LMQ_OFF_PAGE_FRAME, 32'h0000_0000);
        chk("frame", 64'h5, 64'(rd));
        chk("active", 64'h2, 64'(ring_active_o));
        chk("base", 64'ha000, ring_base_o[127:64]);
        acc(1'b1, `LMQ_OFF_RING_SEL, 32'h0000_0000);
        acc(1'b0, `LMQ_OFF_PAGE_FRAME, 32'h0000_0000);
        chk("frame0", 64'h0, 64'(rd));
        acc(1'b1, `LMQ_OFF_RING_SEL, 32'h0000_0001);
        acc(1'b1, `LMQ_OFF_PAGE_FRAME, 32'h0000_0000);
        chk("stopped", 64'h0, 64'(ring_active_o));
        // offered feature words 0, 1 and an undefined word 2
        for (int s = 0; s < 3; s++) begin
            acc(1'b1, `LMQ_OFF_OFFERED_SEL, 32'(s));
            acc(1'b0, `LMQ_OFF_OFFERED, 32'h0000_0000);
            chk("offered", (s == 0) ? 64'h3 : (s == 1) ? 64'h1 : 64'h0,
                64'(rd));
        end
        acc(1'b1, `LMQ_OFF_ACCEPTED_SEL, 32'h0000_0001);
        acc(1'b1, `LMQ_OFF_ACCEPTED, 32'habcd_0123);
        acc(1'b1, `LMQ_OFF_ACCEPTED_SEL, 32'h0000_0002);
        acc(1'b1, `LMQ_OFF_ACCEPTED, 32'hffff_ffff);
        chk("accepted", 64'habcd_0123_0000_0000,
            accepted_features_o);
        // event held until its own bit is acknowledged
        pulse(2'b10);
        chk("irq_set", 64'h1, 64'(irq_o));
        acc(1'b1, `LMQ_OFF_IRQ_CLEAR, 32'h0000_0001);
        acc(1'b0, `LMQ_OFF_IRQ_FLAGS, 32'h0000_0000);
        chk("flags", 64'h2, 64'(rd));
        acc(1'b1, `LMQ_OFF_IRQ_CLEAR, 32'h0000_0002);
        chk("irq_clr", 64'h0, 64'(irq_o));
        acc(1'b1, `LMQ_OFF_DOORBELL, 32'h0000_0001);
        chk("notify", 64'h1, 64'(rang));
        chk("notify_idx", 64'h1, 64'(notify_idx_o));
        // device reset through a zero status write
        acc(1'b1, `LMQ_OFF_RING_SEL, 32'h0000_0000);
        acc(1'b1, `LMQ_OFF_PAGE_FRAME, 32'h0000_0007);
        pulse(2'b01);
        chk("pre_rst", 64'h1, 64'(ring_active_o));
        acc(1'b1, `LMQ_OFF_STATUS, 32'h0000_0000);
        chk("active_dev", 64'h0, 64'(ring_active_o));
        chk("irq_dev", 64'h0, 64'(irq_o));
        chk("page_dev", 64'h1000, 64'(page_bytes_o));
        final_report();
    end
endmodule
